// [logic/rpl_cfg.svh]
// Timing and framing constants for the reversible pulse link port.
// Assumes a 100 MHz system clock; all cycle counts derive from it.
`ifndef RPL_CFG_SVH
`define RPL_CFG_SVH

`define RPL_CLK_NS          10
// Half-pulse durations as transmitted
`define RPL_LONG_HALF_NS    150
`define RPL_SHORT_HALF_NS   50
`define RPL_LONG_HALF_CYC   (`RPL_LONG_HALF_NS / `RPL_CLK_NS)
`define RPL_SHORT_HALF_CYC  (`RPL_SHORT_HALF_NS / `RPL_CLK_NS)
// Receiver: halves shorter than the filter are noise
`define RPL_FILT_NS         20
`define RPL_FILT_CYC        ((`RPL_FILT_NS + `RPL_CLK_NS - 1) / `RPL_CLK_NS)
// Receiver: a half at or above this is a long half
`define RPL_LONG_THR_NS     100
`define RPL_LONG_THR_CYC    (`RPL_LONG_THR_NS / `RPL_CLK_NS)
// Receiver: longest half accepted
`define RPL_WNDW_NS         250
`define RPL_WNDW_CYC        (`RPL_WNDW_NS / `RPL_CLK_NS)
// Wake-up qualification dwell
`define RPL_DWELL_NS        240
`define RPL_DWELL_CYC       ((`RPL_DWELL_NS + `RPL_CLK_NS - 1) / `RPL_CLK_NS)
// Port swap blockout after the last transmitted pulse
`define RPL_BLOCK_NS        2000
`define RPL_BLOCK_CYC       ((`RPL_BLOCK_NS + `RPL_CLK_NS - 1) / `RPL_CLK_NS)
// Window in which the master port listens for a returned bit
`define RPL_RET_WIN_NS      1000
`define RPL_RET_WIN_CYC     (`RPL_RET_WIN_NS / `RPL_CLK_NS)
// Idle timeout and wake time
`define RPL_IDLE_NS         5500000
`define RPL_IDLE_CYC        (`RPL_IDLE_NS / `RPL_CLK_NS)
`define RPL_WAKE_NS         100000
`define RPL_WAKE_CYC        ((`RPL_WAKE_NS + `RPL_CLK_NS - 1) / `RPL_CLK_NS)
// Framing
`define RPL_BYTE_BITS       8
`define RPL_CMD_BITS        32
`define RPL_OWN_BITS        64

`endif

// [logic/rpl_pkg.sv]
// Types shared by the pulse link port modules.
// Assumes nothing of its surroundings.
`default_nettype none

package rpl_pkg;
  typedef enum logic [1:0] {RPL_SLEEP, RPL_WAKING, RPL_READY, RPL_ACTIVE}
    rpl_state_t;
  typedef enum logic [1:0] {RPL_PH_IDLE, RPL_PH_FIRST, RPL_PH_SECOND}
    rpl_phase_t;
endpackage

`default_nettype wire

// [logic/rpl_pulse_rx.sv]
// Pulse classifier for one differential port.
// Inputs are comparator levels from outside the clock domain.
`include "rpl_cfg.svh"
`default_nettype none

module rpl_pulse_rx (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic pos_line,
  input  wire logic neg_line,
  input  wire logic mask,
  output logic      long_pos,
  output logic      long_neg,
  output logic      short_pos,
  output logic      short_neg,
  output logic      wake,
  output logic      act
);

  localparam logic [7:0] FILT  = 8'(`RPL_FILT_CYC);
  localparam logic [7:0] THR   = 8'(`RPL_LONG_THR_CYC);
  localparam logic [7:0] WNDW  = 8'(`RPL_WNDW_CYC);
  localparam logic [7:0] DWELL = 8'(`RPL_DWELL_CYC);

  typedef struct packed {
    logic [1:0]          s1;
    logic [1:0]          s2;
    logic [1:0]          prev;
    rpl_pkg::rpl_phase_t ph;
    logic                neg;
    logic                lng;
    logic [7:0]          cnt;
    logic [7:0]          dwell;
    logic [3:0]          ev;
    logic                wake;
    logic                act;
  } rpl_rx_t;

  rpl_rx_t r;
  rpl_rx_t n;
  logic    pl;
  logic    nl;
  logic    same;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = r;
    n.s1 = {pos_line, neg_line};
    n.s2 = r.s1;
    n.prev = r.s2;
    n.ev = 4'h0;
    n.wake = 1'b0;
    // Both comparators high is common mode, not a differential level
    pl = (r.s2 == 2'b10);
    nl = (r.s2 == 2'b01);
    same = (r.s2 == r.prev);
    n.act = !same;
    if ((pl || nl) && same)
    begin
      if (r.dwell != 8'hFF)
        n.dwell = r.dwell + 8'h01;
      if (r.dwell == DWELL - 8'h01)
        n.wake = 1'b1;
    end
    else
      n.dwell = 8'h00;
    case (r.ph)
      rpl_pkg::RPL_PH_IDLE:
      begin
        if (pl || nl)
        begin
          n.ph = rpl_pkg::RPL_PH_FIRST;
          n.neg = nl;
          n.cnt = 8'h01;
        end
      end
      rpl_pkg::RPL_PH_FIRST:
      begin
        if ((r.neg && nl) || (!r.neg && pl))
        begin
          n.cnt = r.cnt + 8'h01;
          if (r.cnt >= WNDW)
            n.ph = rpl_pkg::RPL_PH_IDLE;
        end
        else if (((r.neg && pl) || (!r.neg && nl)) && r.cnt >= FILT)
        begin
          n.lng = (r.cnt >= THR);
          n.ph = rpl_pkg::RPL_PH_SECOND;
          n.cnt = 8'h01;
        end
        else
          n.ph = rpl_pkg::RPL_PH_IDLE;
      end
      rpl_pkg::RPL_PH_SECOND:
      begin
        if ((r.neg && pl) || (!r.neg && nl))
        begin
          n.cnt = r.cnt + 8'h01;
          if (r.cnt >= WNDW)
            n.ph = rpl_pkg::RPL_PH_IDLE;
        end
        else
        begin
          n.ph = rpl_pkg::RPL_PH_IDLE;
          if (r.cnt >= FILT)
            n.ev = {r.lng && !r.neg, r.lng && r.neg,
                    !r.lng && !r.neg, !r.lng && r.neg};
        end
      end
      default: n.ph = rpl_pkg::RPL_PH_IDLE;
    endcase
    // Own transmission echoes on the comparators and must not decode
    if (mask)
    begin
      n.ph = rpl_pkg::RPL_PH_IDLE;
      n.ev = 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      r <= '0;
    else
      r <= n;
  end

  assign long_pos  = r.ev[3];
  assign long_neg  = r.ev[2];
  assign short_pos = r.ev[1];
  assign short_neg = r.ev[0];
  assign wake      = r.wake;
  assign act       = r.act;

endmodule

`default_nettype wire

// [logic/rpl_link_port.sv]
// Reversible pulse link port: direction control, wake and idle handling,
// pulse forwarding, read return and byte framing.
// Assumes a command decoder and data source in the core on clk_sys.
`include "rpl_cfg.svh"
`default_nettype none

module rpl_link_port #(
  parameter int IDLE_CYC = `RPL_IDLE_CYC,
  parameter int WAKE_CYC = `RPL_WAKE_CYC,
  parameter int OWN_BITS = `RPL_OWN_BITS
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       port_a_mode_select,
  input  wire logic       port_a_pos_line,
  input  wire logic       port_a_neg_line,
  input  wire logic       port_b_pos_line,
  input  wire logic       port_b_neg_line,
  input  wire logic       spi_csb_n,
  input  wire logic       spi_sck,
  input  wire logic       spi_sdi,
  input  wire logic       read_cmd,
  input  wire logic       own_rd_bit,
  output logic            port_a_pos_drive,
  output logic            port_a_neg_drive,
  output logic            port_a_line_oe,
  output logic            port_b_pos_drive,
  output logic            port_b_neg_drive,
  output logic            port_b_line_oe,
  output logic            spi_sdo,
  output logic            int_csb_n,
  output logic            int_sdi,
  output logic            int_sck,
  output logic [7:0]      rx_byte,
  output logic            rx_byte_valid,
  output logic            write_commit,
  output logic            own_rd_take,
  output logic            link_ready,
  output logic            link_awake,
  output logic            slave_is_b
);

  localparam logic [7:0]  LONG_H  = 8'(`RPL_LONG_HALF_CYC - 1);
  localparam logic [7:0]  SHORT_H = 8'(`RPL_SHORT_HALF_CYC - 1);
  localparam logic [15:0] BLOCK   = 16'(`RPL_BLOCK_CYC);
  localparam logic [7:0]  RET_END = 8'(`RPL_RET_WIN_CYC - 1);
  localparam logic [15:0] CMD_B   = 16'(`RPL_CMD_BITS);
  localparam logic [23:0] IDLE_E  = 24'(IDLE_CYC - 1);
  localparam logic [23:0] WAKE_E  = 24'(WAKE_CYC - 1);
  localparam logic [15:0] OWN_N   = 16'(OWN_BITS);

  typedef struct packed {
    rpl_pkg::rpl_state_t             st;
    logic                            mode_s1;
    logic                            mode_s2;
    logic [2:0]                      spi_s1;
    logic [2:0]                      spi_s2;
    logic [2:0]                      spi_prev;
    logic                            wake_a;
    logic                            slave_b;
    logic [23:0]                     idle;
    logic [23:0]                     wcnt;
    logic [15:0]                     blk;
    logic [1:0][7:0]                 tx_cnt;
    logic [1:0][1:0]                 tx_ph;
    logic [1:0]                      tx_neg;
    logic [1:0]                      tx_long;
    logic [1:0]                      dp;
    logic [1:0]                      dn;
    logic                            ret_wait;
    logic [7:0]                      ret_cnt;
    logic                            ret_bit;
    logic                            rd;
    logic [15:0]                     bits;
    logic [15:0]                     own;
    logic [7:0]                      sh;
    logic                            csb;
    logic                            sdi;
    logic                            sck;
    logic [7:0]                      byte_r;
    logic                            byte_vld;
    logic                            commit;
    logic                            take;
    logic                            sdo;
    logic [1:0]                      oe;
    logic                            rdy;
    logic                            awk;
  } rpl_port_t;

  rpl_port_t  r;
  rpl_port_t  n;
  logic [1:0] lpos;
  logic [1:0] lneg;
  logic [1:0] spos;
  logic [1:0] sneg;
  logic [1:0] wake;
  logic [1:0] act;
  logic [1:0] rq;
  logic [1:0] rq_neg;
  logic [1:0] rq_long;
  logic       iso;
  logic       s;
  logic       m;
  logic       spi_act;
  logic       csb_fall;
  logic       csb_rise;
  logic       sck_rise;
  logic       got_bit;
  logic       bit_val;
  logic       out_v;
  logic       out_b;
  logic       rd_now;
  logic       end_frame;

  ////////////////////////////////////////////////////////////////////////////
  rpl_pulse_rx u_rx_a (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .pos_line  (port_a_pos_line),
    .neg_line  (port_a_neg_line),
    .mask      (r.tx_ph[0] != 2'h0),
    .long_pos  (lpos[0]),
    .long_neg  (lneg[0]),
    .short_pos (spos[0]),
    .short_neg (sneg[0]),
    .wake      (wake[0]),
    .act       (act[0])
  );

  rpl_pulse_rx u_rx_b (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .pos_line  (port_b_pos_line),
    .neg_line  (port_b_neg_line),
    .mask      (r.tx_ph[1] != 2'h0),
    .long_pos  (lpos[1]),
    .long_neg  (lneg[1]),
    .short_pos (spos[1]),
    .short_neg (sneg[1]),
    .wake      (wake[1]),
    .act       (act[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = r;
    rq = 2'h0;
    rq_neg = 2'h0;
    rq_long = 2'h0;
    got_bit = 1'b0;
    bit_val = 1'b0;
    out_v = 1'b0;
    out_b = 1'b1;
    rd_now = 1'b0;
    end_frame = 1'b0;
    n.mode_s1 = port_a_mode_select;
    n.mode_s2 = r.mode_s1;
    n.spi_s1 = {spi_csb_n, spi_sck, spi_sdi};
    n.spi_s2 = r.spi_s1;
    n.spi_prev = r.spi_s2;
    n.sck = 1'b0;
    n.byte_vld = 1'b0;
    n.commit = 1'b0;
    n.take = 1'b0;
    iso = r.mode_s2;
    s = r.slave_b;
    m = !r.slave_b;
    spi_act = !iso && (r.spi_s2[2:1] != r.spi_prev[2:1]);
    csb_fall = !iso && r.spi_prev[2] && !r.spi_s2[2];
    csb_rise = !iso && !r.spi_prev[2] && r.spi_s2[2];
    sck_rise = !iso && !r.spi_prev[1] && r.spi_s2[1] && !r.spi_s2[2];

    // Activity timer and blockout timer
    if (act[0] || act[1] || spi_act)
      n.idle = 24'h000000;
    else if (r.idle != IDLE_E)
      n.idle = r.idle + 24'h000001;
    if (r.blk != 16'h0000)
      n.blk = r.blk - 16'h0001;

    case (r.st)
      rpl_pkg::RPL_SLEEP:
      begin
        n.csb = 1'b1;
        if (wake[1] || (iso ? wake[0] : spi_act))
        begin
          n.st = rpl_pkg::RPL_WAKING;
          n.wake_a = !wake[1];
          n.wcnt = 24'h000000;
          n.idle = 24'h000000;
        end
      end
      rpl_pkg::RPL_WAKING:
      begin
        if (r.wcnt == WAKE_E)
        begin
          n.st = rpl_pkg::RPL_READY;
          // Only a wake from below is passed up the chain
          rq[1] = r.wake_a;
          rq_long[1] = 1'b1;
        end
        else
          n.wcnt = r.wcnt + 24'h000001;
      end
      rpl_pkg::RPL_READY:
      begin
        // Wake pulses are absorbed here, nothing is re-sent
        n.csb = 1'b1;
        n.rd = 1'b0;
        n.bits = 16'h0000;
        n.own = 16'h0000;
        if (iso && (lneg[0] || lneg[1]))
        begin
          n.st = rpl_pkg::RPL_ACTIVE;
          n.slave_b = !lneg[0];
          n.csb = 1'b0;
          rq[lneg[0]] = 1'b1;
          rq_neg[lneg[0]] = 1'b1;
          rq_long[lneg[0]] = 1'b1;
        end
        else if (csb_fall)
        begin
          n.st = rpl_pkg::RPL_ACTIVE;
          n.slave_b = 1'b0;
          n.csb = 1'b0;
          rq[1] = 1'b1;
          rq_neg[1] = 1'b1;
          rq_long[1] = 1'b1;
        end
      end
      rpl_pkg::RPL_ACTIVE:
      begin
        n.csb = 1'b0;
        if (iso)
        begin
          if (lpos[s])
            end_frame = 1'b1;
          else if (lneg[m] && r.blk == 16'h0000)
          begin
            // Host reclaims the chain from the other end
            n.slave_b = m;
            n.bits = 16'h0000;
            n.own = 16'h0000;
            n.rd = 1'b0;
            n.ret_wait = 1'b0;
            rq[s] = 1'b1;
            rq_neg[s] = 1'b1;
            rq_long[s] = 1'b1;
          end
          // Long pulses on the master inside blockout fall through here
          else if (spos[s] || sneg[s])
          begin
            got_bit = 1'b1;
            bit_val = spos[s];
          end
        end
        else if (csb_rise)
          end_frame = 1'b1;
        else if (sck_rise)
        begin
          got_bit = 1'b1;
          bit_val = r.spi_s2[0];
        end
        if (end_frame)
        begin
          n.st = rpl_pkg::RPL_READY;
          n.csb = 1'b1;
          n.rd = 1'b0;
          n.ret_wait = 1'b0;
          rq[m] = 1'b1;
          rq_long[m] = 1'b1;
          // Partial bytes are dropped; select held low through the frame
          if (!r.rd && r.bits != 16'h0000 && r.bits[2:0] == 3'h0)
            n.commit = 1'b1;
        end
      end
      default: n.st = rpl_pkg::RPL_SLEEP;
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Bit framing, forwarding and read data selection
    if (got_bit)
    begin
      n.sdi = bit_val;
      n.sck = 1'b1;
      n.sh = {r.sh[6:0], bit_val};
      n.bits = r.bits + 16'h0001;
      if (r.bits[2:0] == 3'h7)
      begin
        n.byte_vld = 1'b1;
        n.byte_r = {r.sh[6:0], bit_val};
      end
      rq[m] = 1'b1;
      rq_neg[m] = !bit_val;
      rd_now = r.rd || (r.bits == CMD_B && read_cmd);
      if (r.bits == CMD_B)
        n.rd = read_cmd;
      if (rd_now && r.own != OWN_N)
      begin
        out_v = 1'b1;
        out_b = own_rd_bit;
        n.take = 1'b1;
        n.own = r.own + 16'h0001;
      end
      else if (rd_now)
      begin
        // Bits from above arrive on the master after forwarding
        n.ret_wait = 1'b1;
        n.ret_cnt = 8'h00;
        n.ret_bit = 1'b1;
      end
    end
    if (r.ret_wait && !end_frame)
    begin
      if (sneg[m])
        n.ret_bit = 1'b0;
      if (r.ret_cnt == RET_END)
      begin
        n.ret_wait = 1'b0;
        out_v = 1'b1;
        out_b = r.ret_bit && !sneg[m];
      end
      else
        n.ret_cnt = r.ret_cnt + 8'h01;
    end
    if (out_v)
    begin
      n.sdo = out_b;
      if (iso && !out_b)
      begin
        rq[s] = 1'b1;
        rq_neg[s] = 1'b1;
        rq_long[s] = 1'b0;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse transmitters; a request on a busy port is dropped, so the
    // far end must space its pulses by at least one pulse length
    for (int p = 0; p < 2; p++)
    begin
      if (r.tx_ph[p] == 2'h0)
      begin
        if (rq[p])
        begin
          n.tx_ph[p] = 2'h1;
          n.tx_neg[p] = rq_neg[p];
          n.tx_long[p] = rq_long[p];
          n.tx_cnt[p] = rq_long[p] ? LONG_H : SHORT_H;
        end
      end
      else if (r.tx_cnt[p] != 8'h00)
        n.tx_cnt[p] = r.tx_cnt[p] - 8'h01;
      else if (r.tx_ph[p] == 2'h1)
      begin
        n.tx_ph[p] = 2'h2;
        n.tx_cnt[p] = r.tx_long[p] ? LONG_H : SHORT_H;
      end
      else
      begin
        n.tx_ph[p] = 2'h0;
        n.blk = BLOCK;
      end
      n.dp[p] = (n.tx_ph[p] == 2'h1 && !n.tx_neg[p]) ||
                (n.tx_ph[p] == 2'h2 && n.tx_neg[p]);
      n.dn[p] = (n.tx_ph[p] == 2'h1 && n.tx_neg[p]) ||
                (n.tx_ph[p] == 2'h2 && !n.tx_neg[p]);
    end

    // Idle entry overrides everything else
    if (r.st != rpl_pkg::RPL_SLEEP && r.idle == IDLE_E)
    begin
      n.st = rpl_pkg::RPL_SLEEP;
      n.csb = 1'b1;
      n.rd = 1'b0;
      n.ret_wait = 1'b0;
    end
    // Status outputs are registered copies, not decodes of state
    n.oe = n.dp | n.dn;
    n.rdy = (n.st == rpl_pkg::RPL_READY) || (n.st == rpl_pkg::RPL_ACTIVE);
    n.awk = (n.st != rpl_pkg::RPL_SLEEP);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      r <= '0;
      r.csb <= 1'b1;
      r.ret_bit <= 1'b1;
      r.sdo <= 1'b1;
      // Select idles high; a zero here would look like a select edge
      r.spi_s1 <= 3'h4;
      r.spi_s2 <= 3'h4;
      r.spi_prev <= 3'h4;
    end
    else
      r <= n;
  end

  assign port_a_pos_drive = r.dp[0];
  assign port_a_neg_drive = r.dn[0];
  assign port_a_line_oe   = r.oe[0];
  assign port_b_pos_drive = r.dp[1];
  assign port_b_neg_drive = r.dn[1];
  assign port_b_line_oe   = r.oe[1];
  assign spi_sdo          = r.sdo;
  assign int_csb_n        = r.csb;
  assign int_sdi          = r.sdi;
  assign int_sck          = r.sck;
  assign rx_byte          = r.byte_r;
  assign rx_byte_valid    = r.byte_vld;
  assign write_commit     = r.commit;
  assign own_rd_take      = r.take;
  assign link_ready       = r.rdy;
  assign link_awake       = r.awk;
  assign slave_is_b       = r.slave_b;

endmodule

`default_nettype wire

// [bench/rpl_link_port_chk.sv]
// Checker for the pulse link port, bound to its top module.
// Assumes one clock and an asynchronous active-low reset.
`default_nettype none
module rpl_link_port_chk (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic port_a_pos_drive,
  input wire logic port_a_neg_drive,
  input wire logic port_b_pos_drive,
  input wire logic int_csb_n,
  input wire logic int_sck,
  input wire logic spi_sdo,
  input wire logic write_commit,
  input wire logic own_rd_take,
  input wire logic link_ready,
  input wire logic link_awake,
  input wire logic slave_is_b
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [4:0] run_r;
  // High run on B's positive drive; halves must be exactly short or long
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      run_r <= 5'h00;
    else
      run_r <= port_b_pos_drive ? run_r + 5'h01 : 5'h00;
  end
  chk_b_half_len: assert property (
    $fell(port_b_pos_drive) |-> run_r inside {5'h05, 5'h0F})
    else $error("pulse half on port B has a wrong length");
  chk_slave_neg_first: assert property (
    $rose(port_a_pos_drive) && !slave_is_b |-> $past(port_a_neg_drive))
    else $error("slave port A started a positive pulse");
  chk_slave_short: assert property (
    $rose(port_a_neg_drive) && !slave_is_b |->
      port_a_neg_drive [*5] ##1 (!port_a_neg_drive && port_a_pos_drive))
    else $error("slave port A sent other than a short negative pulse");
  chk_sck_single: assert property (
    int_sck |=> !int_sck)
    else $error("internal clock pulse longer than one cycle");
  chk_sck_framed: assert property (
    int_sck |-> !int_csb_n && link_ready)
    else $error("internal clock outside an active frame");
  chk_commit_edge: assert property (
    write_commit |-> $rose(int_csb_n))
    else $error("write commit without a select rise");
  chk_read_zero: assert property (
    own_rd_take && !spi_sdo && !slave_is_b |-> ##[0:6] $rose(port_a_neg_drive))
    else $error("no return pulse for a zero read bit");
  chk_read_one: assert property (
    own_rd_take && spi_sdo && !slave_is_b |-> !port_a_neg_drive [*8])
    else $error("return pulse for a one read bit");
  chk_take_framed: assert property (
    own_rd_take |-> !int_csb_n)
    else $error("read bit taken outside a frame");
  chk_sleep_quiet: assert property (
    !link_awake |-> !link_ready && !port_b_pos_drive && !port_a_pos_drive)
    else $error("activity while the port sleeps");
endmodule

bind rpl_link_port rpl_link_port_chk u_chk (
  .clk_sys, .resetn, .port_a_pos_drive, .port_a_neg_drive,
  .port_b_pos_drive, .int_csb_n, .int_sck, .spi_sdo, .write_commit,
  .own_rd_take, .link_ready, .link_awake, .slave_is_b);
`default_nettype wire

// [bench/rpl_far_end.sv]
// Far end of one pulse link port: host translator or chain neighbour.
// Assumes the system clock; it drives its lines at the falling edge.
`default_nettype none
module rpl_far_end (
  input  wire logic clk_sys,
  output logic      pos_line,
  output logic      neg_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // A terminated pair rests at zero difference: both comparators low
  initial {pos_line, neg_line} = 2'h0;
  task automatic send(input bit lng, input bit plus);
    int h;
    h = lng ? 15 : 5;
    @(negedge clk_sys);
    {pos_line, neg_line} = plus ? 2'h2 : 2'h1;
    repeat (h) @(negedge clk_sys);
    {pos_line, neg_line} = plus ? 2'h1 : 2'h2;
    repeat (h) @(negedge clk_sys);
    {pos_line, neg_line} = 2'h0;
  endtask
  // Plain differential level, as used to wake a sleeping port
  task automatic hold(input int n);
    @(negedge clk_sys);
    pos_line = 1'h1;
    repeat (n) @(negedge clk_sys);
    pos_line = 1'h0;
  endtask
endmodule
`default_nettype wire

// [bench/rpl_link_port_tb.sv]
// Testbench for the pulse link port in pulse mode on both ports, then in serial mode on port A.
// Assumes far end models on A and B and the bound checker.
`default_nettype none
module rpl_link_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 1'h0;
  logic       resetn = 1'h0;
  logic       port_a_mode_select = 1'h1;
  logic       read_cmd = 1'h0;
  logic       spi_csb_n = 1'h1;
  logic       spi_sck = 1'h0;
  logic       spi_sdi = 1'h0;
  logic       rx_byte_valid, own_rd_take;
  logic       own_rd_bit = 1'h0;
  logic       port_a_pos_line, port_a_neg_line, port_b_pos_line;
  logic       port_b_neg_line, port_a_pos_drive, port_a_neg_drive;
  logic       port_a_line_oe, port_b_pos_drive, port_b_neg_drive;
  logic       port_b_line_oe, spi_sdo, int_csb_n, int_sdi, int_sck;
  logic       write_commit, link_ready, link_awake, slave_is_b;
  logic [7:0] rx_byte, bp, ap, an, ns, nc, nt, nv;
  logic       b_first, a_first, b_on, a_on;
  int         num_errors = 0;
  int         num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  // Short counts keep the run brief; expectations use these values
  rpl_link_port #(.IDLE_CYC(1500), .WAKE_CYC(20)) uut (
    .clk_sys, .resetn, .port_a_mode_select, .port_a_pos_line,
    .port_a_neg_line, .port_b_pos_line, .port_b_neg_line,
    .spi_csb_n, .spi_sck, .spi_sdi, .read_cmd,
    .own_rd_bit, .port_a_pos_drive, .port_a_neg_drive, .port_a_line_oe,
    .port_b_pos_drive, .port_b_neg_drive, .port_b_line_oe, .spi_sdo,
    .int_csb_n, .int_sdi, .int_sck, .rx_byte, .rx_byte_valid,
    .write_commit, .own_rd_take, .link_ready, .link_awake, .slave_is_b);
  rpl_far_end fa (.clk_sys, .pos_line(port_a_pos_line),
    .neg_line(port_a_neg_line));
  rpl_far_end fb (.clk_sys, .pos_line(port_b_pos_line),
    .neg_line(port_b_neg_line));
  // pulse clears counters on the rising edge; t_wake and spi_ev clear them at a falling edge, alongside this
  always @(negedge clk_sys)
  begin
    if (port_b_pos_drive) bp++;
    if (port_a_pos_drive) ap++;
    if (port_a_neg_drive) an++;
    if (int_sck) ns++;
    if (write_commit) nc++;
    if (own_rd_take) nt++;
    if (rx_byte_valid) nv++;
    if (port_b_line_oe && !b_on) b_first = port_b_pos_drive;
    if (port_a_line_oe && !a_on) a_first = port_a_pos_drive;
    b_on = port_b_line_oe;
    a_on = port_a_line_oe;
  end
  function automatic logic [7:0] z(input logic x);
    return {7'h00, x};
  endfunction
  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One pulse from a far end; spacing leaves room for any return
  task automatic pulse(input bit onb, input bit lng, input bit plus);
    @(posedge clk_sys);
    {bp, ap, an, ns, nc, nt, nv} = '0;
    if (onb) fb.send(lng, plus);
    else fa.send(lng, plus);
    repeat (130) @(negedge clk_sys);
    if (!onb) check("fwd_len", lng ? 8'h0F : 8'h05, bp);
    if (!onb) check("fwd_pol", z(plus), z(b_first));
  endtask
  task automatic t_wake;
    int i;
    bp = 8'h00;
    fa.hold(10);
    repeat (40) @(negedge clk_sys);
    check("short_wake", 8'h00, z(link_awake));
    fa.hold(30);
    for (i = 0; i < 300 && link_ready !== 1'h1; i++) @(negedge clk_sys);
    if (i == 300)
    begin
      num_errors++;
      finish_test();
    end
    repeat (60) @(negedge clk_sys);
    check("wake_len", 8'h0F, bp);
    check("wake_pol", 8'h01, z(b_first));
    bp = 8'h00;
    fa.hold(30);
    repeat (60) @(negedge clk_sys);
    check("no_prop", 8'h00, bp);
  endtask
  task automatic t_write;
    logic [7:0] v;
    v = 8'hA5;
    pulse(0, 1, 0);
    check("csb_low", 8'h00, z(int_csb_n));
    check("slave_b", 8'h00, z(slave_is_b));
    for (int i = 7; i >= 0; i--)
    begin
      pulse(0, 0, v[i]);
      check("sdi", z(v[i]), z(int_sdi));
      check("sck", 8'h01, ns);
      check("no_ret", 8'h00, 8'(ap + an));
      check("byte_vld", z(i == 0), nv);
    end
    check("byte", v, rx_byte);
    pulse(0, 1, 1);
    check("csb_high", 8'h01, z(int_csb_n));
    check("ready", 8'h01, z(link_ready));
    check("commit", 8'h01, nc);
  endtask
  task automatic t_read;
    read_cmd = 1'h1;
    pulse(0, 1, 0);
    repeat (32) pulse(0, 0, 0);
    pulse(0, 0, 1);
    check("ret_len", 8'h05, an);
    check("take", 8'h01, nt);
    check("ret_pol", 8'h00, z(a_first));
    check("sdo_zero", 8'h00, z(spi_sdo));
    own_rd_bit = 1'h1;
    pulse(0, 0, 0);
    check("ret_none", 8'h00, 8'(ap + an));
    check("sdo_one", 8'h01, z(spi_sdo));
    own_rd_bit = 1'h0;
    repeat (62) pulse(0, 0, 1);
    check("sdo_own", 8'h00, z(spi_sdo));
    // Own bits are used up; the next slot is passed through from above
    pulse(0, 0, 1);
    check("chain_take", 8'h00, nt);
    check("chain_one", 8'h01, z(spi_sdo));
    check("chain_ret", 8'h00, 8'(ap + an));
    pulse(0, 1, 1);
    check("rd_commit", 8'h00, nc);
  endtask
  task automatic t_swap;
    pulse(0, 1, 0);
    pulse(1, 1, 0);
    check("blocked", 8'h00, z(slave_is_b));
    repeat (300) @(negedge clk_sys);
    pulse(1, 1, 0);
    check("swapped", 8'h01, z(slave_is_b));
    check("new_master", 8'h0F, an);
    pulse(1, 1, 1);
    check("end_b", 8'h01, z(int_csb_n));
  endtask
  task automatic t_idle;
    repeat (800) @(negedge clk_sys);
    check("awake_mid", 8'h01, z(link_awake));
    repeat (700) @(negedge clk_sys);
    check("asleep", 8'h00, z(link_awake));
  endtask
  // One change of the plain serial pins {select, clock, data}
  task automatic spi_ev(input logic [2:0] pins, input logic [7:0] len,
                        input logic pol);
    {bp, ns} = '0;
    {spi_csb_n, spi_sck, spi_sdi} = pins;
    repeat (80) @(negedge clk_sys);
    check("spi_len", len, bp);
    check("spi_pol", z(pol), z(b_first));
  endtask
  task automatic t_serial;
    port_a_mode_select = 1'h0;
    repeat (5) @(negedge clk_sys);
    spi_ev(3'h0, 8'h0F, 1'h1);
    check("spi_ready", 8'h01, z(link_ready));
    spi_ev(3'h4, 8'h00, 1'h1);
    spi_ev(3'h0, 8'h0F, 1'h0);
    check("spi_csb", 8'h00, z(int_csb_n));
    spi_ev(3'h3, 8'h05, 1'h1);
    check("spi_sck", 8'h01, ns);
    spi_ev(3'h5, 8'h0F, 1'h1);
    check("spi_end", 8'h01, z(int_csb_n));
  endtask
  initial
  begin
    repeat (2) @(negedge clk_sys);
    resetn = 1'h1;
    t_wake();
    t_write();
    t_read();
    t_swap();
    t_idle();
    t_serial();
    finish_test();
  end
endmodule
`default_nettype wire
